// ---- sdcc_defines.svh ----
`ifndef SDCC_DEFINES_SVH
`define SDCC_DEFINES_SVH
`define SDCC_REF_DIV       256
`define SDCC_MOD_DIV       512
`define SDCC_SETTLE_PERIODS 4
`define SDCC_BG_FACTOR     6
`define SDCC_CAL_SELF      3'h1
`define SDCC_CAL_SYS_ZERO  3'h2
`define SDCC_CAL_SYS_FULL  3'h3
`define SDCC_CAL_SYS_OFS   3'h4
`define SDCC_CAL_BACKGND   3'h5
`define SDCC_CAL_SELF_PER  9
`define SDCC_CAL_STEP_PER  4
`endif

// ---- sdcc_pkg.sv ----
`default_nettype none
package sdcc_pkg;
   typedef enum logic [1:0] {
      SDCC_RUN    = 2'h0,
      SDCC_SETTLE = 2'h1,
      SDCC_CAL    = 2'h2
   } sdcc_state_t;
   typedef logic [23:0] sdcc_word_t;
endpackage
`default_nettype wire

// ---- sdcc_core.sv ----
// Operation
// - One polarity bit sets both differential channels unipolar or bipolar together.
// - Polarity changes only output coding: straight binary or offset binary.
// - High-level single-ended channel is always unipolar coded.
// - Conversion runs continuously; no start command exists.
// - Result register refreshes at notch rate; readable any time.
// - Reference sampling strobe is master clock divided by 256, gain independent.
// - All rates and calibration time scale from the master clock.
// - Falling sync edge resets filter and logic to known state.
// - A calibration command with a mode code of 1 to 5 resets the digital filter; codes 0, 6 and 7 do not.
// - Background mode absorbs setting changes after filter settling time.
// - Mode field codes: 1 self, 2 zero, 3 full, 4 offset, 5 background.
// - Ready output goes low when a calibration sequence completes.
// - After a step, data valid only after four output periods.
// - Background calibration divides the output rate by six.
`timescale 1ns/10ps
`default_nettype none
`include "sdcc_defines.svh"
module sdcc_core #(
   parameter int NOTCH_W = 12
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rstn,
   input  wire logic                 sync_n,
   input  wire logic                 bipolar,
   input  wire logic                 chan_high_level,
   input  wire logic [NOTCH_W-1:0]   notch_select_field,
   input  wire logic [2:0]           calibration_mode_field,
   input  wire logic                 cal_cmd,
   input  wire logic                 sample_valid,
   input  wire logic [23:0]          filter_raw,
   output var  logic                 ref_sample_en,
   output var  logic                 mod_sample_en,
   output var  logic                 filter_reset,
   output var  sdcc_pkg::sdcc_word_t result_data,
   output var  logic                 result_ready_n,
   output var  logic                 cal_busy,
   output var  logic                 bg_mode
);
   import sdcc_pkg::*;

   if (NOTCH_W < 1 || NOTCH_W > 16) begin
      $error("NOTCH_W out of range");
   end

   localparam int DEC_W = NOTCH_W + 3;
   localparam logic [7:0] REF_LAST = 8'(`SDCC_REF_DIV - 1);
   localparam logic [8:0] MOD_LAST = 9'(`SDCC_MOD_DIV - 1);

   function automatic logic [3:0] cal_periods(input logic [2:0] md);
      if (md == `SDCC_CAL_SELF || md == `SDCC_CAL_SYS_OFS) begin
         cal_periods = 4'(`SDCC_CAL_SELF_PER);
      end else begin
         cal_periods = 4'(`SDCC_CAL_STEP_PER);
      end
   endfunction

   function automatic logic is_cal_code(input logic [2:0] md);
      is_cal_code = (md >= `SDCC_CAL_SELF) && (md <= `SDCC_CAL_BACKGND);
   endfunction

   logic              sync_d;
   logic              sync_fall;
   logic              cal_start;
   logic [7:0]        ref_cnt;
   logic [8:0]        mod_cnt;
   logic [DEC_W-1:0]  dec_cnt;
   logic [DEC_W-1:0]  dec_last;
   logic              period_tick;
   logic [2:0]        bg_cnt;
   logic              out_tick;
   logic [3:0]        settle_cnt;
   logic [2:0]        cfg_q;
   logic [NOTCH_W-1:0] notch_q;
   logic              cfg_change;
   logic [23:0]       coded;
   sdcc_state_t       state;

   assign sync_fall  = sync_d && !sync_n;
   assign cal_start  = cal_cmd && is_cal_code(calibration_mode_field);
   assign filter_reset = sync_fall || cal_start;
   assign cfg_change = bg_mode && ({bipolar, chan_high_level, 1'b0} != cfg_q
                       || notch_select_field != notch_q);

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sync_d <= 1'b1;
      end else begin
         sync_d <= sync_n;
      end
   end

   // Reference strobe; gain has no input here on purpose
   always_ff @(posedge clk_sys) begin
      if (!rstn || filter_reset) begin
         ref_cnt       <= 8'h00;
         ref_sample_en <= 1'b0;
      end else begin
         ref_cnt       <= (ref_cnt == REF_LAST) ? 8'h00 : ref_cnt + 8'h01;
         ref_sample_en <= (ref_cnt == REF_LAST);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn || filter_reset) begin
         mod_cnt       <= 9'h000;
         mod_sample_en <= 1'b0;
      end else begin
         mod_cnt       <= (mod_cnt == MOD_LAST) ? 9'h000 : mod_cnt + 9'h001;
         mod_sample_en <= (mod_cnt == MOD_LAST);
      end
   end

   // Decimation in modulator samples; zero notch code is treated as one
   assign dec_last = (notch_select_field == '0) ? DEC_W'(7)
                   : {notch_select_field, 3'h0} - DEC_W'(1);

   always_ff @(posedge clk_sys) begin
      if (!rstn || filter_reset) begin
         dec_cnt     <= '0;
         period_tick <= 1'b0;
      end else if (mod_sample_en) begin
         dec_cnt     <= (dec_cnt >= dec_last) ? '0 : dec_cnt + DEC_W'(1);
         period_tick <= (dec_cnt >= dec_last);
      end else begin
         period_tick <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn || filter_reset) begin
         bg_cnt <= 3'h0;
      end else if (period_tick && bg_mode) begin
         bg_cnt <= (bg_cnt == 3'(`SDCC_BG_FACTOR - 1)) ? 3'h0 : bg_cnt + 3'h1;
      end
   end
   assign out_tick = period_tick && (!bg_mode || bg_cnt == 3'(`SDCC_BG_FACTOR - 1));

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         bg_mode <= 1'b0;
      end else if (cal_cmd) begin
         bg_mode <= (calibration_mode_field == `SDCC_CAL_BACKGND);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cfg_q   <= 3'h0;
         notch_q <= '0;
      end else begin
         cfg_q   <= {bipolar, chan_high_level, 1'b0};
         notch_q <= notch_select_field;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state      <= SDCC_SETTLE;
         settle_cnt <= 4'(`SDCC_SETTLE_PERIODS);
         cal_busy   <= 1'b0;
      end else if (cal_start) begin
         state      <= SDCC_CAL;
         settle_cnt <= cal_periods(calibration_mode_field);
         cal_busy   <= (calibration_mode_field != `SDCC_CAL_BACKGND);
      end else if (sync_fall || cfg_change) begin
         state      <= SDCC_SETTLE;
         settle_cnt <= 4'(`SDCC_SETTLE_PERIODS);
      end else if (out_tick) begin
         unique case (state)
            SDCC_RUN: begin
               state <= SDCC_RUN;
            end
            SDCC_SETTLE, SDCC_CAL: begin
               if (settle_cnt <= 4'h1) begin
                  state    <= SDCC_RUN;
                  cal_busy <= 1'b0;
               end
               settle_cnt <= settle_cnt - 4'h1;
            end
            default: begin
               state <= SDCC_SETTLE;
            end
         endcase
      end
   end

   // High-level channel is always straight binary; bipolar flips the MSB
   always_comb begin
      coded = filter_raw;
      if (bipolar && !chan_high_level) begin
         coded = {~filter_raw[23], filter_raw[22:0]};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         result_data    <= 24'h000000;
         result_ready_n <= 1'b1;
      end else if (filter_reset) begin
         result_ready_n <= 1'b1;
      end else if (out_tick && state == SDCC_RUN) begin
         result_data    <= sample_valid ? coded : result_data;
         result_ready_n <= 1'b0;
      end else if (out_tick && settle_cnt <= 4'h1) begin
         result_data    <= coded;
         result_ready_n <= 1'b0;
      end
   end

   property p_ref_period;
      @(posedge clk_sys) disable iff (!rstn || filter_reset)
      ref_sample_en |=> !ref_sample_en [*8];
   endproperty
   a_ref_period: assert property (p_ref_period) else $error("ref strobe too close");

   property p_reset_clears_ready;
      @(posedge clk_sys) disable iff (!rstn)
      filter_reset |=> result_ready_n;
   endproperty
   a_reset_clears_ready: assert property (p_reset_clears_ready)
      else $error("ready not cleared on filter reset");

   property p_sync_fall_resets;
      @(posedge clk_sys) disable iff (!rstn)
      $fell(sync_n) |-> filter_reset
         ##1 (state != SDCC_RUN && !ref_sample_en && !period_tick);
   endproperty
   a_sync_fall_resets: assert property (p_sync_fall_resets)
      else $error("sync edge missed");

   property p_cal_resets;
      @(posedge clk_sys) disable iff (!rstn)
      cal_start |-> filter_reset ##1 (state == SDCC_CAL);
   endproperty
   a_cal_resets: assert property (p_cal_resets) else $error("cal did not reset filter");

   property p_hl_unipolar;
      @(posedge clk_sys) disable iff (!rstn)
      chan_high_level |-> coded == filter_raw;
   endproperty
   a_hl_unipolar: assert property (p_hl_unipolar) else $error("high level coded bipolar");

   property p_bipolar_code;
      @(posedge clk_sys) disable iff (!rstn)
      (bipolar && !chan_high_level) |-> coded[23] != filter_raw[23];
   endproperty
   a_bipolar_code: assert property (p_bipolar_code) else $error("offset binary wrong");

   property p_no_ready_unsettled;
      @(posedge clk_sys) disable iff (!rstn)
      $fell(result_ready_n) |-> $past(out_tick);
   endproperty
   a_no_ready_unsettled: assert property (p_no_ready_unsettled)
      else $error("ready off output tick");

   property p_bg_rate;
      @(posedge clk_sys) disable iff (!rstn)
      (bg_mode && period_tick && bg_cnt != 3'h5) |-> !out_tick;
   endproperty
   a_bg_rate: assert property (p_bg_rate) else $error("background rate not divided");

   // Independent counters, so the checks below do not reuse the dividers they guard
   logic [8:0]        ref_since;
   logic [9:0]        mod_since;
   logic [3:0]        ticks_since;

   always_ff @(posedge clk_sys) begin
      if (!rstn || filter_reset) begin
         ref_since <= 9'h000;
         mod_since <= 10'h000;
      end else begin
         ref_since <= ref_sample_en ? 9'h001 : ref_since + 9'h001;
         mod_since <= mod_sample_en ? 10'h001 : mod_since + 10'h001;
      end
   end

   // Saturates so a long run cannot wrap back under the settle count
   always_ff @(posedge clk_sys) begin
      if (!rstn || filter_reset) begin
         ticks_since <= 4'h0;
      end else if (out_tick && ticks_since != 4'hF) begin
         ticks_since <= ticks_since + 4'h1;
      end
   end

   property p_ref_spacing;
      @(posedge clk_sys) disable iff (!rstn)
      ref_sample_en |-> ref_since == 9'(`SDCC_REF_DIV);
   endproperty
   a_ref_spacing: assert property (p_ref_spacing)
      else $error("ref strobe spacing wrong");

   property p_mod_spacing;
      @(posedge clk_sys) disable iff (!rstn)
      mod_sample_en |-> mod_since == 10'(`SDCC_MOD_DIV);
   endproperty
   a_mod_spacing: assert property (p_mod_spacing)
      else $error("modulator strobe spacing wrong");

   property p_cal_done_ready;
      @(posedge clk_sys) disable iff (!rstn)
      ($fell(cal_busy) && !$past(cal_start)) |-> !result_ready_n;
   endproperty
   a_cal_done_ready: assert property (p_cal_done_ready)
      else $error("calibration ended without ready");

   property p_settle_ticks;
      @(posedge clk_sys) disable iff (!rstn)
      $fell(result_ready_n) |-> ticks_since >= 4'(`SDCC_SETTLE_PERIODS);
   endproperty
   a_settle_ticks: assert property (p_settle_ticks)
      else $error("ready before filter resettled");
endmodule
`default_nettype wire

// ---- sdcc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdcc_host_model (
   input  wire logic        clk_sys,
   output var  logic        sync_n,
   output var  logic        bipolar,
   output var  logic        chan_high_level,
   output var  logic [11:0] notch_select_field,
   output var  logic [2:0]  calibration_mode_field,
   output var  logic        cal_cmd
);
   // Shortest notch keeps every settle and calibration wait brief
   initial begin
      sync_n = 1'b1;
      bipolar = 1'b0;
      chan_high_level = 1'b0;
      notch_select_field = 12'h001;
      calibration_mode_field = 3'h0;
      cal_cmd = 1'b0;
   end
   // One shared edge would line up several converters
   task automatic set_sync(input logic v);
      @(posedge clk_sys);
      sync_n <= v;
   endtask
   // One bit covers both differential channels
   task automatic set_coding(input logic bip, input logic hl);
      @(posedge clk_sys);
      bipolar <= bip;
      chan_high_level <= hl;
   endtask
   // Recalibrate after a coding change
   task automatic issue_cal(input logic [2:0] code);
      @(posedge clk_sys);
      calibration_mode_field <= code;
      cal_cmd <= 1'b1;
   endtask
   task automatic cal_idle();
      @(posedge clk_sys);
      cal_cmd <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- tb_sigma_delta_conversion_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_sigma_delta_conversion_control;
   import sdcc_pkg::*;
   typedef struct packed {logic [2:0] code; logic rst; logic bg;} sdcc_row_t;
   localparam int P = 4096;
   logic                 clk_sys = 1'b0;
   logic                 rstn = 1'b0;
   logic                 sample_valid = 1'b1;
   logic [23:0]          filter_raw = 24'h123456;
   logic                 sync_n;
   logic                 bipolar;
   logic                 chan_high_level;
   logic [11:0]          notch_select_field;
   logic [2:0]           calibration_mode_field;
   logic                 cal_cmd;
   logic                 ref_sample_en;
   logic                 mod_sample_en;
   logic                 filter_reset;
   sdcc_word_t           result_data;
   logic                 result_ready_n;
   logic                 cal_busy;
   logic                 bg_mode;
   int                   n_errors = 0;
   int                   checked = 0;
   int                   n;
   int                   ref_cnt = 0;
   int                   ref_gap = 0;
   int                   mod_cnt = 0;
   int                   mod_gap = 0;
   sdcc_row_t            rows [10] = '{'{3'h5, 1'b1, 1'b1}, '{3'h6, 1'b0, 1'b0},
      '{3'h1, 1'b1, 1'b0}, '{3'h2, 1'b1, 1'b0}, '{3'h3, 1'b1, 1'b0}, '{3'h4, 1'b1, 1'b0},
      '{3'h0, 1'b0, 1'b0}, '{3'h7, 1'b0, 1'b0}, '{3'h5, 1'b1, 1'b1}, '{3'h0, 1'b0, 1'b0}};

   always #2 clk_sys = ~clk_sys;

   sdcc_host_model sdcc_host_model_i (.clk_sys(clk_sys), .sync_n(sync_n), .bipolar(bipolar),
      .chan_high_level(chan_high_level), .notch_select_field(notch_select_field),
      .calibration_mode_field(calibration_mode_field), .cal_cmd(cal_cmd));

   sdcc_core #(.NOTCH_W(12)) sdcc_core_i (.clk_sys(clk_sys), .rstn(rstn), .sync_n(sync_n),
      .bipolar(bipolar), .chan_high_level(chan_high_level),
      .notch_select_field(notch_select_field), .calibration_mode_field(calibration_mode_field),
      .cal_cmd(cal_cmd), .sample_valid(sample_valid), .filter_raw(filter_raw),
      .ref_sample_en(ref_sample_en), .mod_sample_en(mod_sample_en),
      .filter_reset(filter_reset), .result_data(result_data),
      .result_ready_n(result_ready_n), .cal_busy(cal_busy), .bg_mode(bg_mode));

   // Spacing between strobes, measured without trusting any design counter
   always @(posedge clk_sys) begin
      ref_cnt <= ref_sample_en ? 0 : ref_cnt + 1;
      mod_cnt <= mod_sample_en ? 0 : mod_cnt + 1;
      if (ref_sample_en === 1'b1) ref_gap <= ref_cnt + 1;
      if (mod_sample_en === 1'b1) mod_gap <= mod_cnt + 1;
   end

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_ready(output int cnt);
      cnt = 0;
      while (result_ready_n !== 1'b0 && cnt < 8 * P) begin
         @(posedge clk_sys);
         #1;
         cnt++;
      end
   endtask

   task automatic tally_and_finish();
      if (n_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         sdcc_host_model_i.issue_cal(rows[i].code);
         #1;
         check(filter_reset, rows[i].rst);
         if (i > 0) check(bg_mode, rows[i-1].bg);
      end
      sdcc_host_model_i.cal_idle();
      #1;
      check(bg_mode, 1'b0);
      sdcc_host_model_i.set_sync(1'b0);
      #1;
      check(filter_reset, 1'b1);
      sdcc_host_model_i.set_sync(1'b1);
      #1;
      check(result_ready_n, 1'b1);
      wait_ready(n);
      check(n >= 3 * P && n <= 7 * P, 1'b1);
      check(result_data, 24'h123456);
      sdcc_host_model_i.set_coding(1'b1, 1'b1);
      filter_raw <= 24'hABCDEF;
      sdcc_host_model_i.issue_cal(3'h2);
      #1;
      check(filter_reset, 1'b1);
      sdcc_host_model_i.cal_idle();
      #1;
      check({cal_busy, result_ready_n}, 2'h3);
      wait_ready(n);
      check(n >= 3 * P && n <= 7 * P, 1'b1);
      check(cal_busy, 1'b0);
      // The next tick after calibration carries the high-level sample
      repeat (P + 2) @(posedge clk_sys);
      #1;
      check(result_data, 24'hABCDEF);
      check(24'(ref_gap), 24'h000100);
      check(24'(mod_gap), 24'h000200);
      @(posedge clk_sys);
      sample_valid <= 1'b0;
      filter_raw   <= 24'h654321;
      repeat (P) @(posedge clk_sys);
      #1;
      check(result_data, 24'hABCDEF);
      sdcc_host_model_i.set_coding(1'b1, 1'b0);
      sample_valid <= 1'b1;
      repeat (P) @(posedge clk_sys);
      #1;
      check(result_data, 24'hE54321);
      // Reset in mid-run must bring every output back to its idle value
      @(posedge clk_sys);
      rstn <= 1'b0;
      @(posedge clk_sys);
      rstn <= 1'b1;
      #1;
      check({result_ready_n, cal_busy, bg_mode}, 3'h4);
      check(result_data, 24'h000000);
      wait_ready(n);
      check(n >= 3 * P && n <= 7 * P, 1'b1);
      check(result_data, 24'hE54321);
      tally_and_finish();
   end

   initial begin
      repeat (80000) @(posedge clk_sys);
      n_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
